// ==== pkg/checkback_regs.vh ====
// Register map, field positions, reset values and time figures of the checkback scheduler
`ifndef CHECKBACK_REGS_VH
`define CHECKBACK_REGS_VH
// Register byte offsets
`define CB_CTRL_OFS        8'h00
`define CB_SCHED_OFS       8'h04
`define CB_TIMES_OFS       8'h08
`define CB_STATUS_OFS      8'h0c
`define CB_CMD_OFS         8'h10
// Control register fields
`define CB_CTRL_AUTO       0
`define CB_CTRL_TIMED      1
`define CB_CTRL_RECOV      2
`define CB_CTRL_SYNC       3
`define CB_CTRL_FALLBK     4
`define CB_CTRL_CODED      5
`define CB_CTRL_ADDR_LO    8
`define CB_CTRL_RST        12'h000
// Schedule register fields
`define CB_SCHED_PER_LO    0
`define CB_SCHED_REC_LO    8
`define CB_SCHED_RTY_LO    16
`define CB_PERIOD_RST      7'h08
`define CB_RECPER_RST      6'h14
`define CB_RETRY_RST       4'h3
// Times register: four 5-bit hours, one per byte
`define CB_TIMES_RST       32'h14100c08
// Command register fields
`define CB_CMD_TEST        0
`define CB_CMD_CLR_MAJOR   1
// Limits, time figures and CRC constants, each in its own unit
`define CB_PERIOD_MIN_HR   7'd1
`define CB_PERIOD_MAX_HR   7'd120
`define CB_REC_MIN_MIN     6'd5
`define CB_REC_MAX_MIN     6'd60
`define CB_HOUR_MAX        5'd23
`define CB_REC_PASSES      2'd3
`define CB_GRACE_STEP_MIN  13'd5
`define CB_TIMED_OFS_MIN   6'd5
`define CB_SEC_PER_MIN     6'd60
`define CB_MIN_PER_HR      13'd60
`define CB_CAR_BASE_SEC    6'd5
`define CB_CAR_STEP_SEC    6'd5
`define CB_CAR_MAX_ADDR    4'd4
`define CB_REC_OUT_SEC     3'd5
`define CB_SYNC_HOUR       5'd0
`define CB_SYNC_MIN        6'd30
`define CB_CRC_POLY        16'h1021
`define CB_CRC_INIT        16'hffff
`endif

// ==== src/checkback_test_scheduler.v ====
// Checkback test scheduler: timing, recovery, retries, keyed carrier and CRC checking
`include "checkback_regs.vh"
module checkback_test_scheduler #(
  parameter KEY_REPLY_SEC = 5
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire        ack_o,
  input  wire        user_settings_position_i,
  input  wire        front_test_switch_i,
  input  wire        sec_tick_i,
  input  wire [4:0]  rtc_hour_i,
  input  wire [5:0]  rtc_min_i,
  input  wire [5:0]  rtc_sec_i,
  output wire        sync_send_o,
  input  wire        sync_rx_i,
  output wire        rtc_load_o,
  output wire        test_start_o,
  output wire        test_coded_o,
  output wire        test_low_power_o,
  input  wire        test_done_i,
  input  wire        test_pass_i,
  input  wire        rx_test_good_i,
  input  wire        carrier_det_i,
  output wire        key_carrier_o,
  input  wire        rx_bit_i,
  input  wire        rx_bit_valid_i,
  input  wire        rx_msg_end_i,
  output wire        msg_good_o,
  output wire        msg_bad_o,
  output wire        major_alarm_o,
  output wire        recovery_led_o,
  output wire        recovery_out_o
);

  localparam S_IDLE = 2'b01, S_WAIT = 2'b10;
  localparam [31:0] TIMES_RST = `CB_TIMES_RST;

  reg  [11:0] ctrl_q;
  reg  [6:0]  per_hr_q;
  reg  [5:0]  rec_min_q, psec_q, rsec_q, rmin_q, car_sec_q, key_sec_q;
  reg  [3:0]  retry_q, tries_q;
  reg  [4:0]  time_q [0:3];
  reg  [31:0] rdat_q;
  reg  [12:0] pmin_q;
  reg  [1:0]  state_q, pass_cnt_q;
  reg  [2:0]  rout_q;
  reg  [15:0] crc_q;
  reg         ack_q, wr_rej_q, seen_q, pend_q, start_q, coded_q, fb_q, major_q, in_rec_q;
  reg         led_steady_q, blink_q, sync_q, load_q, car_prev_q, key_q, good_q, bad_q, lowp_q;
  wire        auto_en   = ctrl_q[`CB_CTRL_AUTO];
  wire        timed_en  = ctrl_q[`CB_CTRL_TIMED];
  wire        rec_en    = ctrl_q[`CB_CTRL_RECOV];
  wire        sync_en   = ctrl_q[`CB_CTRL_SYNC];
  wire        fb_en     = ctrl_q[`CB_CTRL_FALLBK];
  wire        prim_cd   = ctrl_q[`CB_CTRL_CODED];
  wire [3:0]  addr      = ctrl_q[`CB_CTRL_ADDR_LO+3:`CB_CTRL_ADDR_LO];
  wire        is_master = (addr == 4'h0);
  // Bus request decode
  wire        req    = cyc_i & stb_i & ~ack_q;
  wire        wr     = req & we_i & (&sel_i);
  wire        wr_cfg = wr & ((adr_i == `CB_CTRL_OFS) | (adr_i == `CB_SCHED_OFS)
                             | (adr_i == `CB_TIMES_OFS));
  wire        wr_cmd = wr & (adr_i == `CB_CMD_OFS);
  // Range checks for schedule and times writes
  wire [6:0]  w_per  = dat_i[`CB_SCHED_PER_LO+6:`CB_SCHED_PER_LO];
  wire [5:0]  w_rec  = dat_i[`CB_SCHED_REC_LO+5:`CB_SCHED_REC_LO];
  wire        sched_ok = (w_per >= `CB_PERIOD_MIN_HR) && (w_per <= `CB_PERIOD_MAX_HR) &&
                         (w_rec >= `CB_REC_MIN_MIN) && (w_rec <= `CB_REC_MAX_MIN);
  wire        times_ok = (dat_i[4:0] <= `CB_HOUR_MAX) && (dat_i[12:8] <= `CB_HOUR_MAX) &&
                         (dat_i[20:16] <= `CB_HOUR_MAX) && (dat_i[28:24] <= `CB_HOUR_MAX);
  wire        val_ok = (adr_i == `CB_SCHED_OFS) ? sched_ok :
                       (adr_i == `CB_TIMES_OFS) ? times_ok : 1'b1;
  wire        cfg_take = wr_cfg & user_settings_position_i & val_ok;
  // Test outcome events
  wire        done_ev  = (state_q == S_WAIT) & test_done_i & ~start_q;
  wire        retry_ok = ({1'b0, tries_q} + 5'd1) < {1'b0, retry_q};
  wire        last_fb  = prim_cd & fb_en & ~fb_q;
  wire        pass_ev  = done_ev & test_pass_i;
  wire        fail_ev  = done_ev & ~test_pass_i & ~retry_ok & ~last_fb;
  wire        good_ev  = pass_ev | rx_test_good_i;
  // Schedule triggers
  wire [12:0] per_lim  = {6'h00, per_hr_q} * `CB_MIN_PER_HR;
  wire [12:0] grace    = {9'h000, addr} * `CB_GRACE_STEP_MIN;
  wire        min_ev   = sec_tick_i & (psec_q == `CB_SEC_PER_MIN - 6'd1);
  wire        per_fire = auto_en & ~timed_en & ~in_rec_q & min_ev &
                         ((pmin_q + 13'd1) == (per_lim + grace));
  wire [5:0]  t_min    = `CB_TIMED_OFS_MIN + grace[5:0];
  wire        hr_hit   = (rtc_hour_i == time_q[0]) | (rtc_hour_i == time_q[1]) |
                         (rtc_hour_i == time_q[2]) | (rtc_hour_i == time_q[3]);
  wire        tim_fire = auto_en & timed_en & ~in_rec_q & sec_tick_i & hr_hit &
                         (rtc_min_i == t_min) & (rtc_sec_i == 6'h00) &
                         (is_master | ~seen_q);
  wire        rmin_ev  = sec_tick_i & (rsec_q == `CB_SEC_PER_MIN - 6'd1);
  wire        rec_fire = auto_en & in_rec_q & rmin_ev &
                         ((rmin_q + 6'd1) == rec_min_q);
  wire        man_req  = front_test_switch_i | (wr_cmd & dat_i[`CB_CMD_TEST]);
  wire        auto_req = per_fire | tim_fire | rec_fire;
  // Own carrier duration, none beyond the table
  wire [5:0]  own_dur  = (addr <= `CB_CAR_MAX_ADDR) ?
                         (`CB_CAR_BASE_SEC + {2'b00, addr} * `CB_CAR_STEP_SEC) : 6'h00;
  wire        crc_fb   = crc_q[15] ^ rx_bit_i;
  wire [15:0] crc_nx   = {crc_q[14:0], 1'b0} ^ (crc_fb ? `CB_CRC_POLY : 16'h0000);

  // Wishbone slave: one wait state, unmapped reads give zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) begin
        if (adr_i == `CB_CTRL_OFS) begin
          rdat_q <= {20'h00000, ctrl_q};
        end else if (adr_i == `CB_SCHED_OFS) begin
          rdat_q <= {12'h000, retry_q, 2'b00, rec_min_q, 1'b0, per_hr_q};
        end else if (adr_i == `CB_TIMES_OFS) begin
          rdat_q <= {3'b000, time_q[3], 3'b000, time_q[2], 3'b000, time_q[1],
                     3'b000, time_q[0]};
        end else if (adr_i == `CB_STATUS_OFS) begin
          rdat_q <= {24'h000000, fb_q, wr_rej_q, pass_cnt_q, (state_q == S_WAIT),
                     major_q, recovery_led_o, in_rec_q};
        end else begin
          rdat_q <= 32'h00000000;
        end
      end
    end
  end

  // Configuration registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= `CB_CTRL_RST;
      per_hr_q  <= `CB_PERIOD_RST;
      rec_min_q <= `CB_RECPER_RST;
      retry_q   <= `CB_RETRY_RST;
      time_q[0] <= TIMES_RST[4:0];
      time_q[1] <= TIMES_RST[12:8];
      time_q[2] <= TIMES_RST[20:16];
      time_q[3] <= TIMES_RST[28:24];
      wr_rej_q  <= 1'b0;
    end else begin
      if (wr_cfg) begin
        wr_rej_q <= ~cfg_take;
      end
      if (cfg_take && adr_i == `CB_CTRL_OFS) begin
        ctrl_q <= dat_i[11:0];
      end else if (cfg_take && adr_i == `CB_SCHED_OFS) begin
        per_hr_q  <= w_per;
        rec_min_q <= w_rec;
        retry_q   <= dat_i[`CB_SCHED_RTY_LO+3:`CB_SCHED_RTY_LO];
      end else if (cfg_take && adr_i == `CB_TIMES_OFS) begin
        time_q[0] <= dat_i[4:0];
        time_q[1] <= dat_i[12:8];
        time_q[2] <= dat_i[20:16];
        time_q[3] <= dat_i[28:24];
      end
    end
  end

  // Periodic and recovery timers on the one-second tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      psec_q <= 6'h00;
      pmin_q <= 13'h0000;
      rsec_q <= 6'h00;
      rmin_q <= 6'h00;
      seen_q <= 1'b0;
    end else begin
      if (good_ev || per_fire) begin
        psec_q <= 6'h00;
        pmin_q <= 13'h0000;
      end else if (sec_tick_i) begin
        psec_q <= min_ev ? 6'h00 : psec_q + 6'd1;
        if (min_ev && pmin_q != 13'h1fff) begin
          pmin_q <= pmin_q + 13'd1;
        end
      end
      if (!in_rec_q || rec_fire) begin
        rsec_q <= 6'h00;
        rmin_q <= 6'h00;
      end else if (sec_tick_i) begin
        rsec_q <= rmin_ev ? 6'h00 : rsec_q + 6'd1;
        if (rmin_ev) begin
          rmin_q <= rmin_q + 6'd1;
        end
      end
      // Good test seen since the hour began
      if (good_ev) begin
        seen_q <= 1'b1;
      end else if (sec_tick_i && rtc_min_i == 6'h00 && rtc_sec_i == 6'h00) begin
        seen_q <= 1'b0;
      end
    end
  end

  // Test sequencing with retries and coded-to-uncoded fallback
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      pend_q  <= 1'b0;
      start_q <= 1'b0;
      coded_q <= 1'b0;
      fb_q    <= 1'b0;
      tries_q <= 4'h0;
      lowp_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (man_req || auto_req) begin
        pend_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (pend_q) begin
            pend_q  <= man_req | auto_req;
            start_q <= 1'b1;
            coded_q <= prim_cd;
            lowp_q  <= in_rec_q;
            fb_q    <= 1'b0;
            tries_q <= 4'h0;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (done_ev) begin
            if (test_pass_i) begin
              state_q <= S_IDLE;
            end else if (retry_ok) begin
              tries_q <= tries_q + 4'd1;
              start_q <= 1'b1;
            end else if (last_fb) begin
              fb_q    <= 1'b1;
              coded_q <= 1'b0;
              start_q <= 1'b1;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Major alarm, carrier recovery and indicator
  always @(posedge clk_i) begin
    if (rst_i) begin
      major_q      <= 1'b0;
      in_rec_q     <= 1'b0;
      pass_cnt_q   <= 2'b00;
      led_steady_q <= 1'b0;
      blink_q      <= 1'b0;
      rout_q       <= 3'h0;
    end else begin
      if (fail_ev) begin
        major_q <= 1'b1;
      end else if (pass_ev || (wr_cmd && dat_i[`CB_CMD_CLR_MAJOR])) begin
        major_q <= 1'b0;
      end
      if (!in_rec_q) begin
        pass_cnt_q <= 2'b00;
        blink_q    <= 1'b0;
        if (fail_ev && rec_en && is_master) begin
          in_rec_q     <= 1'b1;
          led_steady_q <= 1'b0;
        end
      end else begin
        if (sec_tick_i) begin
          blink_q <= ~blink_q;
        end
        if (fail_ev) begin
          pass_cnt_q <= 2'b00;
        end else if (pass_ev) begin
          // Manual and scheduled passes count alike
          if (pass_cnt_q + 2'd1 == `CB_REC_PASSES) begin
            in_rec_q     <= 1'b0;
            led_steady_q <= 1'b1;
            rout_q       <= `CB_REC_OUT_SEC;
          end else begin
            pass_cnt_q <= pass_cnt_q + 2'd1;
          end
        end
      end
      if (rout_q != 3'h0 && sec_tick_i && !(pass_ev && in_rec_q)) begin
        rout_q <= rout_q - 3'd1;
      end
    end
  end

  // Daily clock synchronisation
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      sync_q <= is_master & sync_en & auto_en & sec_tick_i & (rtc_hour_i == `CB_SYNC_HOUR) &
                (rtc_min_i == `CB_SYNC_MIN) & (rtc_sec_i == 6'h00);
      load_q <= ~is_master & sync_rx_i;
    end
  end

  // Keyed carrier duration recognition and reply
  always @(posedge clk_i) begin
    if (rst_i) begin
      car_sec_q  <= 6'h00;
      car_prev_q <= 1'b0;
      key_q      <= 1'b0;
      key_sec_q  <= 6'h00;
    end else begin
      car_prev_q <= carrier_det_i;
      if (!carrier_det_i) begin
        car_sec_q <= 6'h00;
      end else if (sec_tick_i && car_sec_q != 6'h3f) begin
        car_sec_q <= car_sec_q + 6'd1;
      end
      if (car_prev_q && !carrier_det_i && !key_q && own_dur != 6'h00 &&
          car_sec_q == own_dur) begin
        key_q     <= 1'b1;
        key_sec_q <= 6'h00;
      end else if (key_q && sec_tick_i) begin
        if (key_sec_q + 6'd1 == KEY_REPLY_SEC[5:0]) begin
          key_q <= 1'b0;
        end
        key_sec_q <= key_sec_q + 6'd1;
      end
    end
  end

  // CRC-16 check over message plus appended check word
  always @(posedge clk_i) begin
    if (rst_i) begin
      crc_q  <= `CB_CRC_INIT;
      good_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      good_q <= 1'b0;
      bad_q  <= 1'b0;
      if (rx_msg_end_i) begin
        good_q <= (crc_q == 16'h0000);
        bad_q  <= (crc_q != 16'h0000);
        crc_q  <= `CB_CRC_INIT;
      end else if (rx_bit_valid_i) begin
        crc_q <= crc_nx;
      end
    end
  end

  // Output drive
  assign dat_o            = rdat_q;
  assign ack_o            = ack_q;
  assign sync_send_o      = sync_q;
  assign rtc_load_o       = load_q;
  assign test_start_o     = start_q;
  assign test_coded_o     = coded_q;
  assign test_low_power_o = lowp_q;
  assign key_carrier_o    = key_q;
  assign msg_good_o       = good_q;
  assign msg_bad_o        = bad_q;
  assign major_alarm_o    = major_q;
  assign recovery_led_o   = in_rec_q ? blink_q : led_steady_q;
  assign recovery_out_o   = (rout_q != 3'h0);

endmodule // checkback_test_scheduler

// ==== test/checkback_test_scheduler_props.sv ====
// Port-level assertions for the checkback scheduler
module checkback_test_scheduler_props #(
  parameter KEY_REPLY_SEC = 5
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire       ack_o,
  input wire       sec_tick_i,
  input wire [4:0] rtc_hour_i,
  input wire [5:0] rtc_min_i,
  input wire       sync_send_o,
  input wire       sync_rx_i,
  input wire       rtc_load_o,
  input wire       test_start_o,
  input wire       test_coded_o,
  input wire       test_low_power_o,
  input wire       test_done_i,
  input wire       test_pass_i,
  input wire       carrier_det_i,
  input wire       key_carrier_o,
  input wire       rx_msg_end_i,
  input wire       msg_good_o,
  input wire       msg_bad_o,
  input wire       major_alarm_o,
  input wire       recovery_led_o,
  input wire       recovery_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0] key_ticks_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Ticks while keyed
  always @(posedge clk_i) begin
    if (rst_i || !key_carrier_o) key_ticks_q <= 4'h0;
    else if (sec_tick_i) key_ticks_q <= key_ticks_q + 4'h1;
  end
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_msg_verdict: assert property (rx_msg_end_i |=> (msg_good_o != msg_bad_o))
    else $error("no verdict");
  a_msg_cause: assert property ((msg_good_o || msg_bad_o) |-> $past(rx_msg_end_i))
    else $error("stray verdict");
  a_alarm_cause: assert property ($rose(major_alarm_o) |-> $past(test_done_i && !test_pass_i))
    else $error("stray alarm");
  a_power_at_start: assert property ($changed(test_low_power_o) |-> test_start_o)
    else $error("power changed mid test");
  a_mode_at_start: assert property ($changed(test_coded_o) |-> test_start_o)
    else $error("mode changed mid test");
  a_key_after_fall: assert property ($rose(key_carrier_o) |-> !carrier_det_i && !$past(carrier_det_i))
    else $error("reply over carrier");
  a_key_bound: assert property (key_ticks_q <= KEY_REPLY_SEC)
    else $error("reply keyed too long");
  a_key_span: assert property ($fell(key_carrier_o) |-> key_ticks_q == KEY_REPLY_SEC)
    else $error("reply keyed too short");
  a_sync_time: assert property (sync_send_o |-> $past(rtc_hour_i) == 5'h00 && $past(rtc_min_i) == 6'h1e)
    else $error("time sent off schedule");
  a_load_cause: assert property (rtc_load_o |-> $past(sync_rx_i) || $past(sync_rx_i, 2))
    else $error("stray clock load");
  a_led_steady: assert property ($rose(recovery_out_o) |-> ##[0:2] recovery_led_o)
    else $error("indicator not steady");
endmodule // checkback_test_scheduler_props

bind checkback_test_scheduler checkback_test_scheduler_props #(.KEY_REPLY_SEC(KEY_REPLY_SEC)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o), .sec_tick_i(sec_tick_i), .rtc_hour_i(rtc_hour_i),
  .rtc_min_i(rtc_min_i), .sync_send_o(sync_send_o), .sync_rx_i(sync_rx_i), .rtc_load_o(rtc_load_o),
  .test_start_o(test_start_o), .test_coded_o(test_coded_o), .test_low_power_o(test_low_power_o),
  .test_done_i(test_done_i), .test_pass_i(test_pass_i), .carrier_det_i(carrier_det_i),
  .key_carrier_o(key_carrier_o), .rx_msg_end_i(rx_msg_end_i), .msg_good_o(msg_good_o),
  .msg_bad_o(msg_bad_o), .major_alarm_o(major_alarm_o), .recovery_led_o(recovery_led_o),
  .recovery_out_o(recovery_out_o));

// ==== test/checkback_test_scheduler_test.sv ====
// Self-checking bench for the checkback scheduler
`include "checkback_regs.vh"
module checkback_test_scheduler_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i, carrier_det_i, sec_tick_i, sync_rx_i, key_q;
  reg         user_settings_position_i, front_test_switch_i, rx_bit_i, rx_bit_valid_i;
  reg         rx_msg_end_i, eng_clr;
  reg  [7:0]  adr_i;
  reg  [31:0] dat_i, rd;
  reg  [4:0]  rtc_hour_i;
  reg  [5:0]  rtc_min_i;
  reg  [3:0]  eng_fails, eng_lat;
  wire [31:0] dat_o;
  wire        ack_o, sync_send_o, rtc_load_o, test_start_o, test_coded_o, test_low_power_o;
  wire        test_done_i, test_pass_i, key_carrier_o, msg_good_o, msg_bad_o, major_alarm_o;
  wire        recovery_led_o, recovery_out_o;
  integer     fail_count, cmp_count, cyc_n, n_start, n_coded, n_low, n_sync, n_load, n_key;
  integer     n_good, n_bad, s0, c0, j;

  checkback_test_scheduler #(.KEY_REPLY_SEC(2)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .user_settings_position_i(user_settings_position_i), .front_test_switch_i(front_test_switch_i),
    .sec_tick_i(sec_tick_i), .rtc_hour_i(rtc_hour_i), .rtc_min_i(rtc_min_i), .rtc_sec_i(6'h00),
    .sync_send_o(sync_send_o), .sync_rx_i(sync_rx_i), .rtc_load_o(rtc_load_o),
    .test_start_o(test_start_o), .test_coded_o(test_coded_o), .test_low_power_o(test_low_power_o),
    .test_done_i(test_done_i), .test_pass_i(test_pass_i), .rx_test_good_i(1'b0),
    .carrier_det_i(carrier_det_i), .key_carrier_o(key_carrier_o), .rx_bit_i(rx_bit_i),
    .rx_bit_valid_i(rx_bit_valid_i), .rx_msg_end_i(rx_msg_end_i), .msg_good_o(msg_good_o),
    .msg_bad_o(msg_bad_o), .major_alarm_o(major_alarm_o), .recovery_led_o(recovery_led_o),
    .recovery_out_o(recovery_out_o));

  test_engine_model u_eng (.clk_i(clk_i), .rst_i(rst_i), .start_i(test_start_o), .clr_i(eng_clr),
    .fails_i(eng_fails), .lat_i(eng_lat), .done_o(test_done_i), .pass_o(test_pass_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Event counters and hang limit
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    n_key = n_key + (key_carrier_o === 1'b1 && !key_q);
    key_q = (key_carrier_o === 1'b1);
    n_start = n_start + (test_start_o === 1'b1);
    n_coded = n_coded + (test_start_o === 1'b1 && test_coded_o === 1'b1);
    n_low = n_low + (test_start_o === 1'b1 && test_low_power_o === 1'b1);
    n_sync = n_sync + (sync_send_o === 1'b1);
    n_load = n_load + (rtc_load_o === 1'b1);
    n_good = n_good + (msg_good_o === 1'b1);
    n_bad = n_bad + (msg_bad_o === 1'b1);
    if (cyc_n == 40000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    end
  endtask

  task idle(input integer n);
    repeat (n) @(posedge clk_i);
  endtask

  task tick(input integer n);
    repeat (n) begin
      @(posedge clk_i) sec_tick_i <= 1'b1;
      @(posedge clk_i) sec_tick_i <= 1'b0;
    end
    @(posedge clk_i);
  endtask

  task at_time(input [4:0] h, input [5:0] m, input integer n);
    begin
      @(posedge clk_i) rtc_hour_i <= h; rtc_min_i <= m;
      tick(n);
    end
  endtask

  task wait_idle;
    begin
      idle(4);
      rd = 32'h8;
      while (rd[3]) wb(1'b0, `CB_STATUS_OFS, 32'h0);
    end
  endtask

  task manual(input [3:0] f);
    begin
      @(posedge clk_i) eng_fails <= f; eng_clr <= 1'b1; front_test_switch_i <= 1'b1;
      @(posedge clk_i) eng_clr <= 1'b0; front_test_switch_i <= 1'b0;
      wait_idle;
      idle(2);
    end
  endtask

  function [15:0] crc_of(input [7:0] b);
    integer k;
    begin
      crc_of = `CB_CRC_INIT;
      for (k = 7; k >= 0; k = k - 1)
        crc_of = {crc_of[14:0], 1'b0} ^ ((crc_of[15] ^ b[k]) ? `CB_CRC_POLY : 16'h0000);
    end
  endfunction

  task send_msg(input [23:0] m);
    integer k;
    begin
      for (k = 23; k >= 0; k = k - 1) begin
        @(posedge clk_i) rx_bit_i <= m[k]; rx_bit_valid_i <= 1'b1;
        @(posedge clk_i) rx_bit_i <= ~m[k]; rx_bit_valid_i <= 1'b0;
      end
      @(posedge clk_i) rx_msg_end_i <= 1'b1;
      @(posedge clk_i) rx_msg_end_i <= 1'b0;
      idle(3);
    end
  endtask

  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    {cyc_i, stb_i, we_i, carrier_det_i, sec_tick_i, sync_rx_i, key_q, front_test_switch_i} = 8'h00;
    {rx_bit_i, rx_bit_valid_i, rx_msg_end_i, eng_clr} = 4'h0;
    {fail_count, cmp_count, cyc_n, n_start, n_coded, n_low, n_sync} = 0;
    {n_load, n_key, n_good, n_bad} = 0;
    adr_i = 8'h00; dat_i = 32'h0; rtc_hour_i = 5'h05; rtc_min_i = 6'h00;
    eng_fails = 4'h0; eng_lat = 4'h1; user_settings_position_i = 1'b0; rst_i = 1'b1;
    idle(12);
    rst_i <= 1'b0;
    // Reset values and an unmapped read
    wb(1'b0, `CB_CTRL_OFS, 32'h0); chk(rd, {20'h0, `CB_CTRL_RST});
    wb(1'b0, `CB_SCHED_OFS, 32'h0);
    chk(rd, {12'h0, `CB_RETRY_RST, 2'h0, `CB_RECPER_RST, 1'b0, `CB_PERIOD_RST});
    wb(1'b0, `CB_TIMES_OFS, 32'h0); chk(rd, `CB_TIMES_RST);
    wb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    $display("reset values done");
    // Settings refused outside user position or range
    for (j = 0; j < 5; j = j + 1) begin
      user_settings_position_i <= (j != 0);
      wb(1'b1, `CB_SCHED_OFS, j == 0 ? 32'h00020501 : j == 1 ? 32'h00020500 :
                              j == 2 ? 32'h00020579 : j == 3 ? 32'h00020401 : 32'h00023d01);
      wb(1'b0, `CB_SCHED_OFS, 32'h0); chk(rd, 32'h00031408);
      wb(1'b0, `CB_STATUS_OFS, 32'h0); chk(rd[6], 1'b1);
    end
    wb(1'b1, `CB_TIMES_OFS, 32'h18100c08); wb(1'b0, `CB_TIMES_OFS, 32'h0);
    chk(rd, `CB_TIMES_RST);
    wb(1'b1, `CB_SCHED_OFS, 32'h00020501); wb(1'b0, `CB_SCHED_OFS, 32'h0);
    chk(rd, 32'h00020501);
    $display("settings guard done");
    // Retries and fallback, two primary attempts each
    for (j = 0; j < 4; j = j + 1) begin
      eng_lat <= j[3:0];
      wb(1'b1, `CB_CMD_OFS, 32'h2);
      wb(1'b1, `CB_CTRL_OFS, j == 1 ? 32'h20 : j == 2 ? 32'h10 : 32'h30);
      s0 = n_start; c0 = n_coded;
      manual(j == 3 ? 4'h2 : 4'hf);
      chk(n_start - s0, (j == 0 || j == 3) ? 3 : 2);
      chk(n_coded - c0, j == 2 ? 0 : 2);
      chk(major_alarm_o, j != 3);
    end
    $display("retry table done");
    // Recovery; a mid failure restarts the pass count
    wb(1'b1, `CB_SCHED_OFS, 32'h00010501);
    wb(1'b1, `CB_CTRL_OFS, 32'h04);
    manual(4'hf);
    wb(1'b0, `CB_STATUS_OFS, 32'h0); chk(rd[0], 1'b1);
    c0 = recovery_led_o; tick(1); chk(recovery_led_o, !c0);
    s0 = n_low;
    manual(4'h0); manual(4'hf); manual(4'h0); manual(4'h0);
    chk(recovery_out_o, 1'b0);
    manual(4'h0);
    chk(recovery_out_o, 1'b1); chk(recovery_led_o, 1'b1);
    wb(1'b0, `CB_STATUS_OFS, 32'h0); chk(rd[0], 1'b0);
    chk(n_low - s0, 5);
    manual(4'h0); chk(n_low - s0, 5);
    tick(6); chk(recovery_out_o, 1'b0); chk(recovery_led_o, 1'b1);
    $display("recovery done");
    // Message check, good then one damaged bit
    send_msg({8'ha5, crc_of(8'ha5)});
    send_msg({8'ha5, crc_of(8'ha5)} ^ 24'h000400);
    chk(n_good, 1); chk(n_bad, 1);
    $display("message check done");
    // Carrier durations, one tick short then exact
    for (j = 0; j < 4; j = j + 1) begin
      wb(1'b1, `CB_CTRL_OFS, {23'h0, j[1], 8'h00});
      s0 = n_key;
      @(posedge clk_i) carrier_det_i <= 1'b1;
      tick(4 + 5 * j[1] + j[0]);
      @(posedge clk_i) carrier_det_i <= 1'b0;
      idle(6); chk(n_key - s0, j[0]);
      tick(3);
    end
    $display("carrier done");
    // Timed master, timed remote, then auto tests off
    wb(1'b1, `CB_CTRL_OFS, 32'h03); s0 = n_start;
    at_time(5'd8, 6'd0, 1); at_time(5'd8, 6'd4, 1); wait_idle; chk(n_start - s0, 0);
    at_time(5'd8, 6'd5, 1); wait_idle; chk(n_start - s0, 1);
    wb(1'b1, `CB_CTRL_OFS, 32'h103);
    at_time(5'd12, 6'd0, 1); at_time(5'd12, 6'd9, 1); wait_idle; chk(n_start - s0, 1);
    at_time(5'd12, 6'd10, 1); wait_idle; chk(n_start - s0, 2);
    wb(1'b1, `CB_CTRL_OFS, 32'h102);
    at_time(5'd16, 6'd0, 1); at_time(5'd16, 6'd10, 2); wait_idle; chk(n_start - s0, 2);
    $display("timed done");
    // Time send at 00:30, load at a remote
    wb(1'b1, `CB_CTRL_OFS, 32'h09); s0 = n_sync;
    at_time(5'd0, 6'd29, 1); at_time(5'd0, 6'd30, 1); idle(3); chk(n_sync - s0, 1);
    wb(1'b1, `CB_CTRL_OFS, 32'h100); s0 = n_load;
    @(posedge clk_i) sync_rx_i <= 1'b1;
    @(posedge clk_i) sync_rx_i <= 1'b0;
    idle(3); chk(n_load - s0, 1);
    $display("clock sync done");
    // One hour period counted from a manual pass
    at_time(5'd5, 6'd0, 1);
    wb(1'b1, `CB_CTRL_OFS, 32'h01); wb(1'b1, `CB_CMD_OFS, 32'h1); wait_idle;
    s0 = n_start;
    tick(3540); chk(n_start - s0, 0);
    j = 0;
    while (n_start == s0 && j < 130) begin
      tick(1);
      j = j + 1;
    end
    chk(n_start - s0, 1);
    $display("periodic done");
    finish_test;
  end
endmodule // checkback_test_scheduler_test

// ==== test/test_engine_model.sv ====
// Behavioural test engine that answers the scheduler's attempt requests
module test_engine_model (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       start_i,
  input  wire       clr_i,
  input  wire [3:0] fails_i,
  input  wire [3:0] lat_i,
  output reg        done_o,
  output reg        pass_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0] wait_q;
  reg [3:0] tries_q;
  reg       busy_q;
  // Answer each attempt lat_i+1 cycles after its start pulse; fail the first fails_i attempts
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    pass_o <= ~pass_o;
    if (rst_i || clr_i) tries_q <= 4'h0;
    if (rst_i) begin
      busy_q <= 1'b0;
      pass_o <= 1'b0;
    end else if (start_i) begin
      busy_q <= 1'b1;
      wait_q <= lat_i;
    end else if (busy_q) begin
      if (wait_q == 4'h0) begin
        busy_q  <= 1'b0;
        done_o  <= 1'b1;
        pass_o  <= (tries_q >= fails_i);
        tries_q <= tries_q + 4'h1;
      end else wait_q <= wait_q - 4'h1;
    end
  end
endmodule // test_engine_model
